// ===== hdl/flash_boot_seq.sv
// boot stream, sector relock and boot configuration command sequencer
`timescale 1ns/10ps
module flash_boot_seq
	import flash_boot_pkg::*;
(
	input  wire logic                   sys_clk,
	input  wire logic                   rst,
	input  wire logic                   spi_clk,
	input  wire logic                   spi_cs_n,
	input  wire logic [3:0]             io_in,
	output logic      [3:0]             io_out,
	output logic      [3:0]             io_oe,
	input  wire logic                   quad_io_allow,
	output logic                        write_permit_latch,
	output logic                        write_busy_flag,
	output logic                        sector_open,
	output logic      [SECTOR_BITS-1:0] open_sector,
	output boot_cfg_t                   boot_stream_config,
	input  wire logic [31:0]            nv_cfg,
	output logic                        nv_wr_start,
	output logic      [31:0]            nv_wr_data,
	input  wire logic                   nv_wr_done,
	output logic                        mem_rd_req,
	output logic      [23:0]            mem_rd_addr,
	input  wire logic                   mem_rd_valid,
	input  wire logic [7:0]             mem_rd_data
);

	////////////////////////////////////////////////////////////////////////
	// pin synchronisers and edge detection
	link_pins_t pin_a;
	link_pins_t pin_b;
	link_pins_t pin_c;

	always_ff @(posedge sys_clk) begin
		pin_a <= '{cs_n: spi_cs_n, sck: spi_clk, io: io_in};
		pin_b <= pin_a;
		pin_c <= pin_b;
	end

	wire sck_rise = pin_b.sck & ~pin_c.sck & ~pin_b.cs_n;
	wire sck_fall = ~pin_b.sck & pin_c.sck & ~pin_b.cs_n;
	wire cs_fall  = ~pin_b.cs_n & pin_c.cs_n;
	wire cs_rise  = pin_b.cs_n & ~pin_c.cs_n;

	////////////////////////////////////////////////////////////////////////
	// state and shared counters

	seq_state_t  st;
	seq_state_t  next_st;
	seq_state_t  dec_st;
	logic [5:0]  bcnt;
	logic [3:0]  dcnt;
	logic [31:0] in_sh;
	logic [31:0] out_sh;
	logic [5:0]  ocnt;
	logic [1:0]  init_phase;
	logic        armed;
	logic        boot_done;
	logic        pending;
	boot_cfg_t   cfg;
	wire [31:0] next_in  = {in_sh[30:0], pin_b.io[0]};
	wire [7:0]  cmd_byte = next_in[7:0];
	wire        in_cmd   = (st == ST_CMD);
	wire        cmd_done = sck_rise & in_cmd & (bcnt == CMD_LAST_BIT);
	wire        shifting = (st == ST_CMD) | (st == ST_ADDR)
	                     | (st == ST_WDATA);
	wire        in_boot  = (st == ST_BOOT_DLY) | (st == ST_BOOT_DATA);
	wire [3:0]  next_dcnt = dcnt + 4'h1;
	// command decode, busy blocks all but status read
	always_comb begin
		dec_st = ST_SKIP;
		case (cmd_byte)
			CMD_STATUS_READ: dec_st = ST_RD_STAT;
			CMD_CFG_READ:    dec_st = write_busy_flag ? ST_SKIP : ST_RD_CFG;
			CMD_CFG_WRITE:   dec_st = (write_permit_latch & ~write_busy_flag)
			                        ? ST_WDATA : ST_SKIP;
			CMD_SECTOR_OPEN: dec_st = write_busy_flag ? ST_SKIP : ST_ADDR;
			default:         dec_st = ST_SKIP;
		endcase
	end

	always_comb begin
		next_st = st;
		if (cs_rise)
			next_st = ST_IDLE;
		else if (cs_fall)
			// boot needs only select and clock
			next_st = !armed ? ST_CMD
			        : (cfg.delay_count == 4'h0) ? ST_BOOT_DATA : ST_BOOT_DLY;
		else if (sck_rise) begin
			case (st)
				ST_CMD:
					if (bcnt == CMD_LAST_BIT)
						next_st = dec_st;
				ST_ADDR:
					if (bcnt == ADDR_LAST_BIT)
						next_st = ST_SKIP;
				ST_BOOT_DLY:
					// hold output for delay count clocks
					if (next_dcnt == cfg.delay_count)
						next_st = ST_BOOT_DATA;
				default: next_st = st;
			endcase
		end
	end

	wire [5:0] next_bcnt = (cs_fall | cmd_done) ? 6'h00
	                     : (sck_rise & shifting & (bcnt != CFG_OVERRUN))
	                     ? bcnt + 6'h01 : bcnt;
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			st   <= ST_IDLE;
			bcnt <= 6'h00;
			dcnt <= 4'h0;
		end else begin
			st   <= (init_phase != 2'h2) ? ST_IDLE : next_st;
			bcnt <= next_bcnt;
			if (cs_fall)
				dcnt <= 4'h0;
			else if (sck_rise & (st == ST_BOOT_DLY))
				dcnt <= next_dcnt;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst)
			in_sh <= 32'h0000_0000;
		else if (sck_rise & shifting)
			in_sh <= next_in;
	end

	////////////////////////////////////////////////////////////////////////
	// sector protection

	wire relock_hit = cmd_done & (cmd_byte == CMD_SECTOR_RELOCK)
	                & ~write_busy_flag;
	wire open_hit   = sck_rise & (st == ST_ADDR) & (bcnt == ADDR_LAST_BIT)
	                & ~sector_open;

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			sector_open <= 1'b0;
			open_sector <= '0;
		end else if (relock_hit)
			sector_open <= 1'b0;
		else if (open_hit) begin
			sector_open <= 1'b1;
			open_sector <= next_in[SECTOR_LSB +: SECTOR_BITS];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// boot configuration write path

	wire permit_hit = cmd_done & (cmd_byte == CMD_WRITE_PERMIT)
	                & ~write_busy_flag;
	// only whole 32 bits then select rise
	wire wr_go      = cs_rise & (st == ST_WDATA) & (bcnt == CFG_DATA_BITS);
	wire wr_finish  = write_busy_flag & nv_wr_done;

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			write_permit_latch <= 1'b0;
			write_busy_flag    <= 1'b0;
			nv_wr_start        <= 1'b0;
			nv_wr_data         <= CFG_RESET;
		end else begin
			nv_wr_start <= wr_go;
			if (wr_go) begin
				write_busy_flag <= 1'b1;
				nv_wr_data      <= lsb_byte_first(in_sh);
			end else if (wr_finish)
				write_busy_flag <= 1'b0;
			if (permit_hit)
				write_permit_latch <= 1'b1;
			else if (wr_finish)
				write_permit_latch <= 1'b0;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst)
			cfg <= CFG_RESET;
		else if (init_phase == 2'h0)
			cfg <= nv_cfg;
		else if (wr_finish)
			cfg <= nv_wr_data;
	end

	assign boot_stream_config = cfg;

	////////////////////////////////////////////////////////////////////////
	// boot arming and prefetch

	logic       fifo_in_ready;
	logic       fifo_out_valid;
	logic [7:0] fifo_out_data;
	logic [23:0] fetch_addr;
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			init_phase <= 2'h0;
			armed      <= 1'b0;
			boot_done  <= 1'b0;
			fetch_addr <= 24'h00_0000;
			pending    <= 1'b0;
		end else begin
			if (init_phase != 2'h2)
				init_phase <= init_phase + 2'h1;
			if (init_phase == 2'h1) begin
				armed      <= cfg.feature_on;
				fetch_addr <= cfg.start_addr;
			end else if (cs_rise & in_boot) begin
				armed     <= 1'b0;
				boot_done <= 1'b1;
			end
			if (mem_rd_req)
				fetch_addr <= fetch_addr + 24'h00_0001;
			if (mem_rd_req)
				pending <= 1'b1;
			else if (mem_rd_valid)
				pending <= 1'b0;
		end
	end

	assign mem_rd_req  = armed & fifo_in_ready & ~pending;
	assign mem_rd_addr = fetch_addr;

	////////////////////////////////////////////////////////////////////////
	// output shifter

	wire       quad_drive = (st == ST_BOOT_DATA) & quad_io_allow;
	wire       out_state  = (st == ST_BOOT_DATA) | (st == ST_RD_CFG)
	                      | (st == ST_RD_STAT);
	wire [5:0] step       = quad_drive ? STEP_QUAD : STEP_SINGLE;
	wire       out_load   = (ocnt == 6'h00);
	wire       boot_pop   = sck_fall & (st == ST_BOOT_DATA) & out_load;
	wire [7:0] stat_byte  = {1'b0, quad_io_allow, 4'h0,
	                         write_permit_latch, write_busy_flag};

	logic [31:0] load_val;
	logic [5:0]  load_len;
	always_comb begin
		load_val = 32'h0000_0000;
		load_len = BYTE_LEN;
		case (st)
			ST_BOOT_DATA: load_val = {fifo_out_data, 24'h00_0000};
			ST_RD_CFG: begin
				load_val = lsb_byte_first(cfg);
				load_len = WORD_LEN;
			end
			ST_RD_STAT: load_val = {stat_byte, 24'h00_0000};
			default: load_val = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			out_sh <= 32'h0000_0000;
			ocnt   <= 6'h00;
		end else if (st == ST_IDLE)
			ocnt <= 6'h00;
		else if (sck_fall & out_state) begin
			out_sh <= out_load ? load_val : out_sh << step;
			ocnt   <= (out_load ? load_len : ocnt) - step;
		end
	end

	// quad enable selects four or one line for boot data, config and status reads use one line
	assign io_out = quad_drive ? out_sh[31:28]
	              : {2'b00, out_sh[31], 1'b0};
	assign io_oe  = pin_b.cs_n ? OE_OFF
	              : quad_drive ? OE_QUAD
	              : out_state ? OE_SINGLE : OE_OFF;

	stream_fifo #(
		.WIDTH (BYTE_W),
		.DEPTH (FIFO_DEPTH)
	) boot_fifo (
		.sys_clk   (sys_clk),
		.rst       (rst),
		.in_valid  (mem_rd_valid),
		.in_ready  (fifo_in_ready),
		.in_data   (mem_rd_data),
		.out_valid (fifo_out_valid),
		.out_ready (boot_pop),
		.out_data  (fifo_out_data)
	);

	////////////////////////////////////////////////////////////////////////
	// checks

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);
	a_relock_closes: assert property (
		relock_hit |=> !sector_open)
		else $error("sector still open after relock");
	a_one_sector: assert property (
		sector_open && !relock_hit |=> $stable(open_sector))
		else $error("open sector changed while open");
	a_boot_needs_arm: assert property (
		$rose(in_boot) |-> $past(armed) && cfg.feature_on)
		else $error("boot stream without enable");
	a_no_rearm: assert property (
		boot_done |=> boot_done && !armed)
		else $error("boot stream armed again");
	a_quad_lines: assert property (
		st == ST_BOOT_DATA && !pin_b.cs_n
		|-> io_oe == (quad_io_allow ? OE_QUAD : OE_SINGLE))
		else $error("wrong boot output width");
	a_wr_busy: assert property (
		wr_go |=> write_busy_flag && nv_wr_start ##1 !nv_wr_start)
		else $error("busy flag not raised by write");
	a_wr_permit: assert property (
		wr_go |-> write_permit_latch)
		else $error("write accepted without permit");
	a_permit_clear: assert property (
		wr_finish |=> !write_permit_latch && !write_busy_flag)
		else $error("permit latch kept after write");
	a_fetch_step: assert property (
		mem_rd_req |=> mem_rd_addr == $past(mem_rd_addr) + 24'h00_0001)
		else $error("boot address did not step");
	a_cs_ends: assert property (
		cs_rise && init_phase == 2'h2 |=> st == ST_IDLE)
		else $error("select rise did not end transfer");

endmodule

// ===== pkg/flash_boot_pkg.sv
// constants, layouts and states shared by the boot stream sequencer
package flash_boot_pkg;

	localparam logic [7:0] CMD_WRITE_PERMIT  = 8'h06;
	localparam logic [7:0] CMD_STATUS_READ   = 8'h05;
	localparam logic [7:0] CMD_CFG_READ      = 8'h14;
	localparam logic [7:0] CMD_CFG_WRITE     = 8'h15;
	localparam logic [7:0] CMD_SECTOR_RELOCK = 8'h24;
	localparam logic [7:0] CMD_SECTOR_OPEN   = 8'h26;

	localparam logic [5:0] CMD_LAST_BIT   = 6'h07;
	localparam logic [5:0] ADDR_LAST_BIT  = 6'h17;
	localparam logic [5:0] CFG_DATA_BITS  = 6'h20;
	localparam logic [5:0] CFG_OVERRUN    = 6'h21;
	localparam logic [5:0] BYTE_LEN       = 6'h08;
	localparam logic [5:0] WORD_LEN       = 6'h20;
	localparam logic [5:0] STEP_QUAD      = 6'h04;
	localparam logic [5:0] STEP_SINGLE    = 6'h01;
	localparam int         SECTOR_LSB     = 12;
	localparam int         SECTOR_BITS    = 12;
	localparam int         FIFO_DEPTH     = 4;
	localparam int         BYTE_W         = 8;
	localparam logic [3:0] OE_QUAD        = 4'hF;
	localparam logic [3:0] OE_SINGLE      = 4'h2;
	localparam logic [3:0] OE_OFF         = 4'h0;
	localparam logic [31:0] CFG_RESET     = 32'h0000_0000;

	// boot configuration word layout, bit 31 down to bit 0
	typedef struct packed {
		logic [23:0] start_addr;
		logic [2:0]  spare;
		logic [3:0]  delay_count;
		logic        feature_on;
	} boot_cfg_t;

	// serial link pins as seen after synchronising
	typedef struct packed {
		logic       cs_n;
		logic       sck;
		logic [3:0] io;
	} link_pins_t;

	typedef enum logic [8:0] {
		ST_IDLE      = 9'h001,
		ST_CMD       = 9'h002,
		ST_ADDR      = 9'h004,
		ST_WDATA     = 9'h008,
		ST_RD_CFG    = 9'h010,
		ST_RD_STAT   = 9'h020,
		ST_BOOT_DLY  = 9'h040,
		ST_BOOT_DATA = 9'h080,
		ST_SKIP      = 9'h100
	} seq_state_t;

	// word sent least significant byte first, each byte msb first
	function automatic logic [31:0] lsb_byte_first(input logic [31:0] w);
		return {w[7:0], w[15:8], w[23:16], w[31:24]};
	endfunction

endpackage

// ===== hdl/stream_fifo.sv
// small valid/ready fifo in flip-flops
`timescale 1ns/10ps
module stream_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 4
) (
	input  wire logic             sys_clk,
	input  wire logic             rst,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);

	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CW = $clog2(DEPTH + 1);
	localparam logic [CW-1:0] FULL_COUNT = CW'(DEPTH);
	localparam logic [PW-1:0] LAST_SLOT  = PW'(DEPTH - 1);

	logic [WIDTH-1:0] slots [DEPTH];
	logic [PW-1:0]    wr_ptr;
	logic [PW-1:0]    rd_ptr;
	logic [CW-1:0]    count;
	wire              do_push = in_valid & in_ready;
	wire              do_pop  = out_valid & out_ready;

	assign in_ready  = (count != FULL_COUNT);
	assign out_valid = (count != '0);
	assign out_data  = slots[rd_ptr];

	always_ff @(posedge sys_clk) begin
		if (do_push)
			slots[wr_ptr] <= in_data;
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count  <= '0;
		end else begin
			if (do_push)
				wr_ptr <= (wr_ptr == LAST_SLOT) ? '0 : wr_ptr + 1'b1;
			if (do_pop)
				rd_ptr <= (rd_ptr == LAST_SLOT) ? '0 : rd_ptr + 1'b1;
			count <= count + CW'(do_push) - CW'(do_pop);
		end
	end

endmodule

// ===== tb/link_host.sv
// host side of the serial link, clock idles low
`timescale 1ns/10ps
module link_host (
	output logic            spi_clk,
	output logic            spi_cs_n,
	output logic [3:0]      host_io,
	input  wire logic [3:0] io_wire
);
	initial begin
		spi_clk = 1'b0;
		spi_cs_n = 1'b1;
		host_io = 4'hA;
	end

	////////////////////////////////////////////////////////////
	// select only, no command
	task automatic sel(input bit low);
		spi_cs_n <= !low;
		#100;
	endtask

	task automatic shift(input int n, input logic [63:0] d,
		input bit qd, output logic [63:0] q);
		q = '0;
		for (int i = n - 1; i >= 0; i--) begin
			host_io <= {~host_io[3:1], d[i]};
			#62.5;
			spi_clk <= 1'b1;
			#1;
			if (qd) begin
				q = {q[59:0], io_wire};
			end else begin
				q = {q[62:0], io_wire[1]};
			end
			#61.5;
			spi_clk <= 1'b0;
		end
	endtask
endmodule

// ===== tb/tb_top.sv
// self-checking bench for the boot stream sequencer
`timescale 1ns/10ps
module tb_top;
	import flash_boot_pkg::*;

	logic             sys_clk = 1'b0;
	logic             rst;
	logic             quad_io_allow;
	logic             spi_clk;
	logic             spi_cs_n;
	logic [3:0]       host_io;
	logic [3:0]       io_out;
	logic [3:0]       io_oe;
	wire  [3:0]       io_wire;
	logic             write_permit_latch;
	logic             write_busy_flag;
	logic             sector_open;
	logic [11:0]      open_sector;
	boot_cfg_t        boot_stream_config;
	logic [31:0]      nv_cfg;
	logic [31:0]      nv_preset = 32'h0000_0000;
	logic             nv_poke = 1'b1;
	logic             nv_wr_start;
	logic [31:0]      nv_wr_data;
	logic             nv_wr_done;
	logic             mem_rd_req;
	logic [23:0]      mem_rd_addr;
	logic             mem_rd_valid;
	logic [7:0]       mem_rd_data;
	logic             mem_busy = 1'b0;
	logic [23:0]      mem_at;
	logic [2:0]       lat;
	logic [8:0]       nv_lat = 9'h000;
	int               n_fail = 0;
	int               checks_done = 0;
	int               n_starts = 0;
	int               n_reqs = 0;

	always #5 sys_clk = ~sys_clk;
	assign io_wire = (io_oe & io_out) | (~io_oe & host_io);

	flash_boot_seq u_dut (
		.sys_clk(sys_clk), .rst(rst), .spi_clk(spi_clk),
		.spi_cs_n(spi_cs_n), .io_in(io_wire), .io_out(io_out),
		.io_oe(io_oe), .quad_io_allow(quad_io_allow),
		.write_permit_latch(write_permit_latch),
		.write_busy_flag(write_busy_flag),
		.sector_open(sector_open), .open_sector(open_sector),
		.boot_stream_config(boot_stream_config),
		.nv_cfg(nv_cfg), .nv_wr_start(nv_wr_start),
		.nv_wr_data(nv_wr_data), .nv_wr_done(nv_wr_done),
		.mem_rd_req(mem_rd_req), .mem_rd_addr(mem_rd_addr),
		.mem_rd_valid(mem_rd_valid), .mem_rd_data(mem_rd_data)
	);

	link_host u_host (
		.spi_clk(spi_clk), .spi_cs_n(spi_cs_n),
		.host_io(host_io), .io_wire(io_wire)
	);

	////////////////////////////////////////////////////////////
	// memory array with random latency
	always @(posedge sys_clk) begin
		mem_rd_valid <= 1'b0;
		if (mem_rd_req) begin
			n_reqs <= n_reqs + 1;
		end
		if (rst) begin
			mem_busy <= 1'b0;
			mem_rd_data <= 8'h00;
		end else if (mem_rd_req && !mem_busy) begin
			mem_busy <= 1'b1;
			mem_at <= mem_rd_addr;
			lat <= 3'($urandom_range(1, 5));
		end else if (mem_busy) begin
			lat <= lat - 3'h1;
			if (lat == 3'h1) begin
				mem_rd_valid <= 1'b1;
				mem_rd_data <= mem_byte(mem_at);
				mem_busy <= 1'b0;
			end
		end
	end

	// non-volatile store, slow write
	always @(posedge sys_clk) begin
		nv_wr_done <= 1'b0;
		if (rst && nv_poke) begin
			nv_cfg <= nv_preset;
		end
		if (nv_wr_start) begin
			n_starts <= n_starts + 1;
			nv_lat <= 9'h0FA;
		end else if (nv_lat != 9'h000) begin
			nv_lat <= nv_lat - 9'h001;
			if (nv_lat == 9'h001) begin
				nv_wr_done <= 1'b1;
				nv_cfg <= nv_wr_data;
			end
		end
	end

	////////////////////////////////////////////////////////////
	function automatic logic [7:0] mem_byte(input logic [23:0] a);
		return a[7:0] ^ a[15:8] ^ 8'h3C;
	endfunction

	function automatic logic [31:0] wire_cfg(input logic [31:0] w);
		return {w[7:0], w[15:8], w[23:16], w[31:24]};
	endfunction

	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		checks_done++;
		if (g !== e) begin
			n_fail++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic do_reset();
		rst <= 1'b1;
		repeat (12) @(posedge sys_clk);
		rst <= 1'b0;
		repeat (10) @(posedge sys_clk);
	endtask

	task automatic frame(input int n, input logic [63:0] d);
		logic [63:0] q;
		u_host.sel(1'b1);
		u_host.shift(n, d, 1'b0, q);
		u_host.sel(1'b0);
	endtask

	task automatic boot_run(input bit qd, input bit on);
		logic [23:0] sa;
		logic [3:0]  dl;
		logic [31:0] cfg;
		logic [63:0] q;
		int          r0;
		sa = 24'($urandom);
		dl = 4'($urandom_range(1, 15));
		cfg = {sa, 3'h0, dl, on};
		r0 = n_reqs;
		@(posedge sys_clk);
		quad_io_allow <= qd;
		nv_preset <= cfg;
		nv_poke <= 1'b1;
		do_reset();
		nv_poke <= 1'b0;
		chk("cfg load", cfg, boot_stream_config);
		if (on) begin
			u_host.sel(1'b1);
			u_host.shift(32'(dl), 64'h0, 1'b0, q);
			u_host.shift(qd ? 8 : 32, 64'h0, qd, q);
			u_host.sel(1'b0);
			chk("boot", {mem_byte(sa), mem_byte(sa + 24'h1),
				mem_byte(sa + 24'h2), mem_byte(sa + 24'h3)},
				q[31:0]);
		end else begin
			chk("no fetch", 32'h0, 32'(n_reqs - r0));
		end
		u_host.sel(1'b1);
		u_host.shift(8, 64'(CMD_CFG_READ), 1'b0, q);
		u_host.shift(64, 64'h0, 1'b0, q);
		u_host.sel(1'b0);
		chk("cfg rd", wire_cfg(cfg), q[63:32]);
		chk("cfg rpt", wire_cfg(cfg), q[31:0]);
		$display("boot test done quad %0d on %0d", qd, on);
	endtask

	task automatic sec_test();
		logic [23:0] a;
		a = 24'($urandom);
		frame(32, {CMD_SECTOR_OPEN, a});
		chk("open", 32'h1, 32'(sector_open));
		chk("sector", 32'(a[23:12]), 32'(open_sector));
		frame(32, {CMD_SECTOR_OPEN, ~a});
		chk("one open", 32'(a[23:12]), 32'(open_sector));
		frame(8, 64'(CMD_SECTOR_RELOCK));
		chk("relock", 32'h0, 32'(sector_open));
		$display("sector test done");
	endtask

	task automatic wr_test();
		logic [31:0] nw;
		logic [31:0] w0;
		logic [63:0] q;
		int          s0;
		nw = {24'($urandom), 3'h0, 4'($urandom), 1'b0};
		w0 = boot_stream_config;
		s0 = n_starts;
		frame(40, {CMD_CFG_WRITE, wire_cfg(nw)});
		chk("no permit", 32'(s0), 32'(n_starts));
		frame(8, 64'(CMD_WRITE_PERMIT));
		chk("permit", 32'h1, 32'(write_permit_latch));
		frame(39, {CMD_CFG_WRITE, 31'(wire_cfg(nw) >> 1)});
		chk("short wr", 32'(s0), 32'(n_starts));
		chk("cfg kept", w0, boot_stream_config);
		frame(8, 64'(CMD_WRITE_PERMIT));
		frame(40, {CMD_CFG_WRITE, wire_cfg(nw)});
		chk("busy", 32'h1, 32'(write_busy_flag));
		u_host.sel(1'b1);
		u_host.shift(16, 64'(CMD_STATUS_READ) << 8, 1'b0, q);
		u_host.sel(1'b0);
		chk("status", 32'h03, 32'(q[7:0]));
		for (int i = 0; i < 400 && write_busy_flag !== 1'b0; i++) begin
			@(posedge sys_clk);
		end
		#1;
		chk("done", 32'h0, 32'(write_busy_flag));
		chk("new cfg", nw, boot_stream_config);
		chk("permit off", 32'h0, 32'(write_permit_latch));
		chk("one start", 32'(s0 + 1), 32'(n_starts));
		@(posedge sys_clk);
		do_reset();
		chk("kept", nw, boot_stream_config);
		$display("write test done");
	endtask

	task automatic summarize();
		$display("checks %0d mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	////////////////////////////////////////////////////////////
	initial begin
		#400_000;
		n_fail++;
		summarize();
	end

	initial begin
		void'($urandom(32'h60BFD490));
		quad_io_allow <= 1'b0;
		do_reset();
		boot_run(1'b0, 1'b1);
		boot_run(1'b1, 1'b1);
		boot_run(1'b0, 1'b0);
		sec_test();
		wr_test();
		summarize();
	end
endmodule
